// >>> logic/spcc_ctrl.sv
// sleep, power and low-frequency clock controller with apb registers
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "spcc_map.svh"
module spcc_ctrl #(
  parameter int unsigned STABLE_CYC = `SPCC_XTAL_STABLE_CYC,
  parameter int unsigned FAIL_CYC = `SPCC_XTAL_FAIL_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_any,
  input wire spcc_pkg::spcc_wake_t wake_irq,
  input wire logic watchdog_restart,
  input wire logic xtal_osc_ok,
  input wire logic lowfreq_clock_pin_a_i,
  input wire logic lowfreq_clock_pin_b_i,
  output logic lowfreq_clock_pin_a_o,
  output logic lowfreq_clock_pin_a_oe,
  output logic lowfreq_clock_pin_b_o,
  output logic lowfreq_clock_pin_b_oe,
  output logic lowfreq_pullup_off,
  output logic lowfreq_ext_clk,
  output logic cpu_clk_en,
  output logic ram_power_on,
  output logic lf_osc_run,
  output logic analog_power_on,
  output logic transceiver_clk_en,
  output logic transceiver_power_on,
  output logic core_power_on,
  output logic warm_start,
  output logic [2:0] lf_rc_trim
);
  import spcc_pkg::*;

  // ********************
  // reset release
  // ********************
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ********************
  // pin synchronisers
  // ********************
  logic [5:0] sync1_q, sync2_q;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {xtal_osc_ok, lowfreq_clock_pin_a_i, wake_irq.dio,
                  wake_irq.wake_timer, wake_irq.comparator,
                  wake_irq.pulse_counter};
      sync2_q <= sync1_q;
    end
  end
  logic osc_ok_s, pin_a_s, dio_s, wt_s, cmp_s, pc_s;
  assign {osc_ok_s, pin_a_s, dio_s, wt_s, cmp_s, pc_s} = sync2_q;
  logic unused_pin_b;
  assign unused_pin_b = lowfreq_clock_pin_b_i;

  // ********************
  // apb decode
  // ********************
  logic wr_en, rd_en, addr_ok;
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  always_comb begin
    case (paddr)
      `SPCC_OFF_STATUS, `SPCC_OFF_CTRL, `SPCC_OFF_SLEEP,
      `SPCC_OFF_LFSEL, `SPCC_OFF_TRIM: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // ********************
  // control register
  // ********************
  // bit0 doze request (self clearing), bit1 radio clock on, bit2 analogue on
  logic xcvr_on_q, analog_on_q, doze_req;
  assign doze_req = wr_en && paddr == `SPCC_OFF_CTRL && pwdata[0];
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      xcvr_on_q <= 1'b1;
      analog_on_q <= 1'b1;
    end else if (wr_en && paddr == `SPCC_OFF_CTRL) begin
      xcvr_on_q <= pwdata[1];
      analog_on_q <= pwdata[2];
    end
  end
  assign transceiver_clk_en = xcvr_on_q;
  assign transceiver_power_on = core_power_on;

  // ********************
  // power state machine
  // ********************
  spcc_state_t state_q;
  spcc_sleep_t mode_q;
  logic sleep_req, wake_ev, deep_wake;
  assign sleep_req = wr_en && paddr == `SPCC_OFF_SLEEP &&
                     pwdata[2:0] <= 3'h4;
  // timer wake counts only while the oscillator keeps running
  assign deep_wake = dio_s;
  always_comb begin
    case (mode_q)
      sleep_osc_on_ram_on, sleep_osc_on_ram_off:
        wake_ev = dio_s | wt_s | cmp_s | pc_s;
      sleep_osc_off_ram_on, sleep_osc_off_ram_off:
        wake_ev = dio_s | cmp_s | pc_s;
      default: wake_ev = deep_wake;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= st_run;
    end else begin
      case (state_q)
        st_run: begin
          if (sleep_req) begin
            state_q <= st_sleep;
          end else if (doze_req) begin
            state_q <= st_doze;
          end
        end
        st_doze: begin
          if (irq_any) begin
            state_q <= st_run;
          end
        end
        st_sleep: begin
          if (wake_ev) begin
            state_q <= st_wake;
          end
        end
        st_wake: state_q <= st_run;
        default: state_q <= st_run;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= sleep_osc_on_ram_on;
    end else if (state_q == st_run && sleep_req) begin
      mode_q <= spcc_sleep_t'(pwdata[2:0]);
    end
  end
  logic in_sleep, ram_mode, osc_mode;
  assign in_sleep = state_q == st_sleep;
  assign ram_mode = mode_q == sleep_osc_on_ram_on ||
                    mode_q == sleep_osc_off_ram_on;
  assign osc_mode = mode_q == sleep_osc_on_ram_on ||
                    mode_q == sleep_osc_on_ram_off;
  assign cpu_clk_en = state_q == st_run || state_q == st_wake;
  assign ram_power_on = !in_sleep || ram_mode;
  assign lf_osc_run = !in_sleep || osc_mode;
  assign core_power_on = !in_sleep || mode_q != sleep_full_powerdown;
  assign analog_power_on = analog_on_q && !in_sleep;

  // ********************
  // restart flags
  // ********************
  logic cycle_q, ramkept_q, deep_q, wdog_q, warm_q;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cycle_q <= 1'b0;
      ramkept_q <= 1'b0;
      deep_q <= 1'b0;
      wdog_q <= 1'b0;
      warm_q <= 1'b0;
    end else if (watchdog_restart) begin
      wdog_q <= 1'b1;
      cycle_q <= 1'b0;
      ramkept_q <= 1'b0;
      deep_q <= 1'b0;
      warm_q <= 1'b0;
    end else if (state_q == st_wake) begin
      cycle_q <= 1'b1;
      ramkept_q <= ram_mode;
      deep_q <= mode_q == sleep_full_powerdown;
      warm_q <= ram_mode;
      wdog_q <= 1'b0;
    end
  end
  assign warm_start = warm_q;

  // ********************
  // low-frequency source
  // ********************
  spcc_lfsrc_t src_q;
  logic lf_rdy_q, xtal_fail_q, settling_q;
  logic [31:0] wait_q;
  logic sel_wr;
  // once external, writes are ignored, so there is no path back to rc
  assign sel_wr = wr_en && paddr == `SPCC_OFF_LFSEL &&
                  src_q == lf_internal_rc &&
                  (pwdata[1:0] == 2'h1 || pwdata[1:0] == 2'h2);
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      src_q <= lf_internal_rc;
    end else if (sel_wr) begin
      src_q <= spcc_lfsrc_t'(pwdata[1:0]);
    end
  end
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lf_rdy_q <= 1'b0;
      xtal_fail_q <= 1'b0;
      settling_q <= 1'b1;
      wait_q <= 32'h0;
    end else if (sel_wr || (state_q == st_wake && !osc_mode)) begin
      lf_rdy_q <= 1'b0;
      settling_q <= 1'b1;
      wait_q <= 32'h0;
    end else if (settling_q) begin
      wait_q <= wait_q + 32'h1;
      if (src_q == ext_crystal_source) begin
        if (osc_ok_s && wait_q >= STABLE_CYC - 1) begin
          lf_rdy_q <= 1'b1;
          settling_q <= 1'b0;
        end else if (wait_q >= FAIL_CYC - 1) begin
          xtal_fail_q <= 1'b1;
          lf_rdy_q <= 1'b1;
          settling_q <= 1'b0;
        end
      end else if (wait_q >= `SPCC_RC_STABLE_CYC - 1) begin
        lf_rdy_q <= 1'b1;
        settling_q <= 1'b0;
      end
    end
  end
  logic ext_run;
  assign ext_run = src_q != lf_internal_rc && lf_rdy_q &&
                   !xtal_fail_q;
  assign lowfreq_ext_clk = ext_run ? pin_a_s : 1'b0;
  // pins only ever listen; the crystal source also releases the pull-ups
  assign lowfreq_clock_pin_a_o = 1'b0;
  assign lowfreq_clock_pin_b_o = 1'b0;
  assign lowfreq_clock_pin_a_oe = 1'b0;
  assign lowfreq_clock_pin_b_oe = 1'b0;
  assign lowfreq_pullup_off = src_q == ext_crystal_source;

  // ********************
  // rc trim
  // ********************
  logic [2:0] trim_q;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      trim_q <= `SPCC_TRIM_RESET;
    end else if (wr_en && paddr == `SPCC_OFF_TRIM &&
                 !pwdata[2] && pwdata[1]) begin
      trim_q <= pwdata[2:0];
    end
  end
  assign lf_rc_trim = trim_q;

  // ********************
  // read mux
  // ********************
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[`SPCC_ST_CYCLE] = cycle_q;
    status[`SPCC_ST_RAMKEPT] = ramkept_q;
    status[`SPCC_ST_ANALOG] = analog_power_on;
    status[`SPCC_ST_XCVR] = xcvr_on_q;
    status[`SPCC_ST_WDOG] = wdog_q;
    status[`SPCC_ST_LFRDY] = lf_rdy_q;
    status[`SPCC_ST_DEEP] = deep_q;
  end
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SPCC_OFF_STATUS: prdata <= {16'h0, status};
        `SPCC_OFF_CTRL: prdata <= {29'h0, analog_on_q, xcvr_on_q, 1'b0};
        `SPCC_OFF_SLEEP: prdata <= {29'h0, mode_q};
        `SPCC_OFF_LFSEL: prdata <= {28'h0, xtal_fail_q, ext_run, src_q};
        `SPCC_OFF_TRIM: prdata <= {29'h0, trim_q};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ********************
  // checks
  // ********************
  sequence s_ready_low2;
    !lf_rdy_q ##1 !lf_rdy_q;
  endsequence
  a_doze_holds_cpu: assert property (
    @(posedge mclk) disable iff (!rst_n_q) state_q == st_doze && !irq_any
    |=> !cpu_clk_en) else $error("cpu clock ran during doze");
  a_doze_keeps_ram: assert property (
    @(posedge mclk) disable iff (!rst_n_q) state_q == st_doze |->
    ram_power_on && core_power_on) else $error("doze cut ram");
  a_no_timer_wake: assert property (
    @(posedge mclk) disable iff (!rst_n_q) in_sleep && !osc_mode && !dio_s
    && !cmp_s && !pc_s |=> in_sleep) else $error("woke without source");
  a_deep_dio_only: assert property (
    @(posedge mclk) disable iff (!rst_n_q) in_sleep && !dio_s &&
    mode_q == sleep_full_powerdown |=> in_sleep)
    else $error("deep sleep woke wrongly");
  a_warm_entry: assert property (
    @(posedge mclk) disable iff (!rst_n_q) state_q == st_wake &&
    !watchdog_restart |=> warm_start == $past(ram_mode))
    else $error("wrong restart entry");
  a_no_return_rc: assert property (
    @(posedge mclk) disable iff (!rst_n_q) src_q != lf_internal_rc |=>
    src_q == $past(src_q)) else $error("source changed after external chosen");
  a_ready_clears: assert property (
    @(posedge mclk) disable iff (!rst_n_q) sel_wr |=> s_ready_low2)
    else $error("ready not cleared on select");
  a_status_unused: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    (status & ~`SPCC_STATUS_USED) == 16'h0000)
    else $error("unused status bit set");
  a_trim_ignored: assert property (
    @(posedge mclk) disable iff (!rst_n_q) wr_en && paddr == `SPCC_OFF_TRIM
    && pwdata[2] |=> $stable(trim_q)) else $error("trim changed by 4-7");
  a_xtal_pins_in: assert property (
    @(posedge mclk) disable iff (!rst_n_q) src_q == ext_crystal_source |->
    !lowfreq_clock_pin_a_oe && !lowfreq_clock_pin_b_oe && lowfreq_pullup_off)
    else $error("crystal pins not released");
endmodule

// >>> logic/spcc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SPCC_MAP_SVH
`define SPCC_MAP_SVH
`define SPCC_OFF_STATUS 12'h000
`define SPCC_OFF_CTRL 12'h004
`define SPCC_OFF_SLEEP 12'h008
`define SPCC_OFF_LFSEL 12'h00c
`define SPCC_OFF_TRIM 12'h010
`define SPCC_ST_CYCLE 0
`define SPCC_ST_RAMKEPT 1
`define SPCC_ST_ANALOG 2
`define SPCC_ST_XCVR 3
`define SPCC_ST_WDOG 7
`define SPCC_ST_LFRDY 10
`define SPCC_ST_DEEP 11
`define SPCC_STATUS_USED 16'h0c8f
`define SPCC_TRIM_RESET 3'h2
`define SPCC_TRIM_HIGH 3'h2
`define SPCC_TRIM_LOW 3'h3
`define SPCC_CLK_MHZ 200
`define SPCC_XTAL_STABLE_MS 1000
`define SPCC_XTAL_FAIL_MS 8000
`define SPCC_XTAL_STABLE_CYC (`SPCC_XTAL_STABLE_MS * 1000 * `SPCC_CLK_MHZ)
`define SPCC_XTAL_FAIL_CYC (`SPCC_XTAL_FAIL_MS * 1000 * `SPCC_CLK_MHZ)
`define SPCC_RC_STABLE_CYC 32'h0000_0010
`endif

// >>> logic/spcc_pkg.sv
// types for the sleep, power and low-frequency clock controller
package spcc_pkg;
  typedef enum logic [2:0] {
    sleep_osc_on_ram_on = 3'h0,
    sleep_osc_on_ram_off = 3'h1,
    sleep_osc_off_ram_on = 3'h2,
    sleep_osc_off_ram_off = 3'h3,
    sleep_full_powerdown = 3'h4
  } spcc_sleep_t;
  typedef enum logic [1:0] {
    lf_internal_rc = 2'h0,
    ext_rc_module_source = 2'h1,
    ext_crystal_source = 2'h2
  } spcc_lfsrc_t;
  typedef enum logic [2:0] {
    st_run = 3'h0,
    st_doze = 3'h1,
    st_sleep = 3'h3,
    st_wake = 3'h2
  } spcc_state_t;
  typedef struct packed {
    logic dio;
    logic wake_timer;
    logic comparator;
    logic pulse_counter;
  } spcc_wake_t;
endpackage

// >>> verification/spcc_lf_partner.sv
// behavioural external low-frequency crystal or rc clock module
`timescale 1ns/1ps
module spcc_lf_partner #(
  parameter int START = 10,
  parameter int HALF = 4
) (
  input wire logic mclk,
  input wire logic xtal_sel,
  input wire logic rc_mode,
  input wire logic dead,
  output logic osc_ok,
  output logic pin_a,
  output logic pin_b
);
  // ********
  // oscillator start-up and pin behaviour
  // ********
  int cnt = 0;
  int div = 0;
  logic ph = 1'b0;
  // once started it runs until xtal_sel drops, sleep included
  always @(posedge mclk) begin
    if (!xtal_sel) cnt <= 0;
    else if (cnt < START) cnt <= cnt + 1;
    div <= (div == HALF - 1) ? 0 : div + 1;
    if (div == HALF - 1) ph <= ~ph;
  end
  assign osc_ok = !dead && cnt == START;
  // idle pin floats to its pull-up, or churns once the pull-up is off
  always @(posedge mclk) begin
    if (rc_mode || osc_ok) pin_a <= ph;
    else if (xtal_sel) pin_a <= ~pin_a;
    else pin_a <= 1'b1;
  end
  assign pin_b = ~pin_a;
endmodule

// >>> verification/tb.sv
// self-checking bench for the sleep, power and low-frequency controller
`timescale 1ns/1ps
`include "spcc_map.svh"
module tb;
  import spcc_pkg::*;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, irq_any, err;
  logic wdog, osc_ok, pa, pb, rc_mode, dead, pu_off, ext_clk, cpu_en;
  logic ram_on, osc_run, ana_on, x_clk, x_pwr, core_on, warm, a_oe, b_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] trim;
  logic a_o, b_o;
  spcc_wake_t wake_irq;
  int errors = 0;
  int tests_run = 0;
  spcc_ctrl #(.STABLE_CYC(20), .FAIL_CYC(100)) uut (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_any(irq_any),
    .wake_irq(wake_irq), .watchdog_restart(wdog), .xtal_osc_ok(osc_ok),
    .lowfreq_clock_pin_a_i(pa), .lowfreq_clock_pin_b_i(pb),
    .lowfreq_clock_pin_a_o(a_o), .lowfreq_clock_pin_a_oe(a_oe),
    .lowfreq_clock_pin_b_o(b_o), .lowfreq_clock_pin_b_oe(b_oe),
    .lowfreq_pullup_off(pu_off), .lowfreq_ext_clk(ext_clk),
    .cpu_clk_en(cpu_en), .ram_power_on(ram_on), .lf_osc_run(osc_run),
    .analog_power_on(ana_on), .transceiver_clk_en(x_clk),
    .transceiver_power_on(x_pwr), .core_power_on(core_on),
    .warm_start(warm), .lf_rc_trim(trim));
  spcc_lf_partner lf (.mclk(mclk), .xtal_sel(pu_off), .rc_mode(rc_mode),
    .dead(dead), .osc_ok(osc_ok), .pin_a(pa), .pin_b(pb));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ********
  // shared tasks
  // ********
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic hang(input string n);
    errors++;
    $display("timeout waiting for %s", n);
    end_sim();
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one edge of slack at the end lets the write land before outputs are read
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) hang("apb");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic poll(input int b);
    int n;
    for (n = 0; n < 300; n++) begin
      apb(0, `SPCC_OFF_STATUS, 0);
      if (rd[b] === 1'b1) break;
    end
    if (n == 300) hang("status");
  endtask
  task automatic wcpu(input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge mclk);
      if (cpu_en === 1'b1) break;
    end
    if (n == lim) hang("cpu clock");
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_regs();
    logic [2:0] tw [5] = '{3'h3, 3'h5, 3'h1, 3'h7, 3'h2};
    logic [2:0] te [5] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h2};
    chk("trim reset", `SPCC_TRIM_RESET, trim);
    poll(`SPCC_ST_LFRDY);
    chk("status", 32'h040c, rd);
    apb(1, `SPCC_OFF_STATUS, 32'hffff);
    apb(0, `SPCC_OFF_STATUS, 0);
    chk("status ro", 32'h040c, rd);
    apb(0, 12'h014, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    for (int i = 0; i < 5; i++) begin
      apb(1, `SPCC_OFF_TRIM, tw[i]);
      chk("trim", te[i], trim);
    end
    apb(1, `SPCC_OFF_CTRL, 32'h4);
    chk("radio clock", 0, x_clk);
    chk("radio power", 1, x_pwr);
    apb(1, `SPCC_OFF_CTRL, 32'h2);
    chk("analog", 0, ana_on);
    apb(0, `SPCC_OFF_STATUS, 0);
    chk("status bits", 32'h0408, rd);
    apb(1, `SPCC_OFF_CTRL, 32'h6);
    wdog <= 1'b1;
    @(posedge mclk);
    wdog <= 1'b0;
    apb(0, `SPCC_OFF_STATUS, 0);
    chk("watchdog flag", 1, rd[`SPCC_ST_WDOG]);
    $display("test regs done");
  endtask
  task automatic t_doze();
    apb(1, `SPCC_OFF_CTRL, 32'h7);
    repeat (4) @(posedge mclk);
    chk("cpu halted", 0, cpu_en);
    chk("ram kept", 1, ram_on);
    chk("radio running", 1, x_clk);
    irq_any <= 1'b1;
    wcpu(4);
    irq_any <= 1'b0;
    $display("test doze done");
  endtask
  task automatic t_sleep();
    spcc_wake_t src [4] = '{4'b0100, 4'b0001, 4'b1000, 4'b0010};
    poll(`SPCC_ST_LFRDY);
    apb(1, `SPCC_OFF_SLEEP, 32'h5);
    chk("bad mode ignored", 1, cpu_en);
    for (int m = 0; m < 4; m++) begin
      apb(1, `SPCC_OFF_SLEEP, m);
      repeat (2) @(posedge mclk);
      chk("ram power", !m[0], ram_on);
      chk("osc run", !m[1], osc_run);
      chk("cpu off", 0, cpu_en);
      if (m[1]) begin
        wake_irq <= 4'b0100;
        repeat (8) @(posedge mclk);
        chk("timer no wake", 0, cpu_en);
      end
      wake_irq <= src[m];
      wcpu(12);
      wake_irq <= 4'b0000;
      apb(0, `SPCC_OFF_STATUS, 0);
      chk("warm start", !m[0], warm);
      chk("unused bits", 0, rd & 32'hffff_f370);
      chk("wake flags", {!m[0], 1'b1}, rd[1:0]);
      chk("deep flag", 0, rd[11]);
    end
    $display("test sleep done");
  endtask
  task automatic t_deep();
    apb(1, `SPCC_OFF_SLEEP, 32'h4);
    repeat (2) @(posedge mclk);
    chk("core off", 0, core_on);
    chk("ram off", 0, ram_on);
    wake_irq <= 4'b0111;
    repeat (8) @(posedge mclk);
    chk("deep stays", 0, cpu_en);
    wake_irq <= 4'b1000;
    wcpu(12);
    wake_irq <= 4'b0000;
    apb(0, `SPCC_OFF_STATUS, 0);
    chk("deep flag", 1, rd[11]);
    chk("cold start", 0, warm);
    $display("test deep done");
  endtask
  task automatic t_lf(input logic [1:0] s, input logic f);
    int n;
    logic p;
    do_reset();
    dead <= f;
    // rc module drives pin a hard with its pull-up left on; only the crystal source takes the pull-up off
    rc_mode <= (s == 2'h1);
    poll(`SPCC_ST_LFRDY);
    apb(1, `SPCC_OFF_LFSEL, s);
    apb(0, `SPCC_OFF_STATUS, 0);
    chk("ready cleared", 0, rd[10]);
    apb(0, `SPCC_OFF_LFSEL, 0);
    chk("not yet running", 0, rd[2]);
    chk("pullup off", s[1], pu_off);
    chk("pins input", 0, {a_oe, b_oe, a_o, b_o});
    poll(`SPCC_ST_LFRDY);
    apb(0, `SPCC_OFF_LFSEL, 0);
    chk("lf state", {f, !f}, rd[3:2]);
    if (!f) begin
      apb(1, `SPCC_OFF_LFSEL, s ^ 2'h3);
      apb(0, `SPCC_OFF_LFSEL, 0);
      chk("source kept", s, rd[1:0]);
      n = 0;
      p = ext_clk;
      repeat (24) begin
        @(posedge mclk);
        if (ext_clk !== p) n++;
        p = ext_clk;
      end
      chk("ext clock moves", 1, n > 2);
    end
    $display("test low-frequency source done");
  endtask
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_any = 1'b0;
    wake_irq = 4'b0000;
    wdog = 1'b0;
    rc_mode = 1'b0;
    dead = 1'b0;
    do_reset();
    t_regs();
    t_doze();
    t_sleep();
    t_deep();
    t_lf(2'h1, 1'b0);
    t_lf(2'h2, 1'b0);
    t_lf(2'h2, 1'b1);
    end_sim();
  end
endmodule
